// ### core/asc_map.svh
`ifndef ASC_MAP_SVH
`define ASC_MAP_SVH

// serial word layout, bit positions counted in the received 16-bit word
`define ASC_FRAME_BITS 5'h10
`define ASC_MUX_EDGE 5'h0E
`define ASC_POS_WRITE 11
`define ASC_POS_SEQ 10
`define ASC_POS_ADDR_HI 9
`define ASC_POS_ADDR_LO 6
`define ASC_POS_PM_HI 5
`define ASC_POS_PM_LO 4
`define ASC_POS_SHADOW 3

// control register after reset: normal power, sequencer unused, channel 0
`define ASC_CTRL_RESET 11'h032

// wake-up time from shutdown, and the core clock rate
`define ASC_WAKE_NS 1000
`define ASC_CLK_MHZ 25
`define ASC_WAKE_CYC ((`ASC_WAKE_NS * `ASC_CLK_MHZ + 999) / 1000)

`endif

// ### core/asc_pkg.sv
package asc_pkg;

   // control register fields, in word order from bit 10 down to bit 0
   typedef struct packed {
      logic sequence_enable;
      logic [3:0] channel_address;
      logic power_mode_hi;
      logic power_mode_lo;
      logic shadow_select;
      logic weak_drive;
      logic range_single;
      logic coding_binary;
   } asc_ctrl_s;

   typedef enum logic [1:0] {
      SEQ_OFF = 2'b00,
      SEQ_SHADOW = 2'b01,
      SEQ_CONSEC = 2'b10
   } asc_seq_e;

   typedef enum logic [1:0] {
      PWR_ACTIVE = 2'b00,
      PWR_STANDBY = 2'b01,
      PWR_SHUTDOWN = 2'b10,
      PWR_WAKING = 2'b11
   } asc_pwr_e;

endpackage

// ### core/asc_sequencer.sv
// Function
// (RQ1) power bits 1,1 keep the converter fully powered regardless of inputs.
// (RQ2) power bits 1,0 power everything down while control contents are kept.
// (RQ3) full shutdown lasts until a later control write changes the power bits.
// (RQ4) power bits 0,1 shut down after each conversion that updates control.
// (RQ5) host waits one microsecond wake-up before expecting a valid conversion.
// (RQ6) power bits 0,0 enter standby, ready after one dummy transfer.
// (RQ7) sequence bits 0,0: each conversion uses the previously written address.
// (RQ8) sequence bits 0,1: next serial word loads the channel-select register.
// (RQ9) selected channels convert in turn, one per chip-select falling edge.
// (RQ10) sequence bits 1,0 keep a running sequence, other bits still update.
// (RQ11) sequence bits 1,1 convert channels 0 up to the address, ascending.
// (RQ12) in consecutive mode the host need not rewrite anything per transfer.
// (RQ13) channel-select register is 16 bits, write-only, taken on falling edges.
// (RQ14) loading channel-select takes sixteen serial clock falling edges.
// (RQ15) channel-select data accepted only after a control write with 0,1.
// (RQ16) channel-select word arrives msb first, one bit per channel 0 to 15.
// (RQ17) sequence repeats from lowest; stops on a write with bits not 1,0.
// (RQ18) host leaves sequencing with write bit 1 and both sequence bits 0.
// (RQ19) serial clock is both transfer clock and conversion step clock.
// (RQ20) control bit 1 selects span of reference or twice the reference.
// (RQ21) address bits take effect at conversion end, for the next transfer.
// (RQ22) the input mux switches channel at the 14th serial falling edge.
// (RQ23) shadow-select bit is at position 3, read with the sequence bit.
// (RQ24) during a sequence host keeps write bit low or data input low.
// (RQ25) sequence bit 10, power pair 5 and 4, sampled msb first.
// (RQ26) after the highest enabled channel the sequence restarts at lowest.
`timescale 1ns/1ps
`include "asc_map.svh"

module asc_sequencer #(
   parameter int CHANNELS = 16
) (
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic i_sclk,
   input wire logic i_cs_n,
   input wire logic i_din,
   output asc_pkg::asc_ctrl_s o_ctrl,
   output asc_pkg::asc_pwr_e o_power_state,
   output asc_pkg::asc_seq_e o_seq_mode,
   output logic [15:0] o_channel_select,
   output logic [3:0] o_mux_channel,
   output logic [3:0] o_conv_channel,
   output logic o_range_double,
   output logic o_ready
);

   localparam logic [7:0] WAKE_CYC = 8'(`ASC_WAKE_CYC);

   // ---------------- link side, runs on serial clock falling edges
   logic [4:0] bit_count;
   logic [15:0] link_shift;
   logic [13:0] link_head;
   logic link_mux_flag;
   logic link_done_flag;

   // bit counter doubles as the conversion step count; cleared while deselected
   always_ff @(negedge i_sclk or posedge i_cs_n) begin
      if (i_cs_n) begin
         bit_count <= 5'h00;
      end else if (bit_count != `ASC_FRAME_BITS) begin // [RQ19] [RQ14]
         bit_count <= bit_count + 5'h01;
      end
   end

   // serial data in, msb first; extra edges beyond sixteen are ignored
   // the head (word bits 15 down to 2) is frozen at edge 14 so the core may read it
   always_ff @(negedge i_sclk) begin
      if (!i_cs_n && bit_count != `ASC_FRAME_BITS) begin
         link_shift <= {link_shift[14:0], i_din}; // [RQ13] [RQ16] [RQ25]
      end
      if (!i_cs_n && bit_count == `ASC_MUX_EDGE - 5'h01) begin
         link_head <= {link_shift[12:0], i_din}; // [RQ22]
      end
   end

   // level flags for the core; they drop only when chip select rises
   always_ff @(negedge i_sclk or posedge i_cs_n) begin
      if (i_cs_n) begin
         link_mux_flag <= 1'b0;
         link_done_flag <= 1'b0;
      end else begin
         if (bit_count == `ASC_MUX_EDGE - 5'h01) begin
            link_mux_flag <= 1'b1; // [RQ22]
         end
         if (bit_count == `ASC_FRAME_BITS - 5'h01) begin
            link_done_flag <= 1'b1; // [RQ14]
         end
      end
   end

   // ---------------- crossing into the core clock
   logic cs_s1, cs_s2, cs_s3;
   logic mux_s1, mux_s2, mux_s3;
   logic done_s1, done_s2, done_s3;
   logic conv_start;
   logic mux_event;
   logic word_taken;

   // two flops per level, a third only for edge detection
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         {cs_s1, cs_s2, cs_s3} <= 3'h7;
         {mux_s1, mux_s2, mux_s3} <= 3'h0;
         {done_s1, done_s2, done_s3} <= 3'h0;
      end else begin
         {cs_s1, cs_s2, cs_s3} <= {i_cs_n, cs_s1, cs_s2};
         {mux_s1, mux_s2, mux_s3} <= {link_mux_flag, mux_s1, mux_s2};
         {done_s1, done_s2, done_s3} <= {link_done_flag, done_s1, done_s2};
      end
   end

   assign conv_start = cs_s3 & ~cs_s2;
   assign mux_event = mux_s2 & ~mux_s3;
   // shift word is static here: no sclk edges remain until the next frame
   assign word_taken = done_s2 & ~done_s3;

   logic wr_bit;
   logic [1:0] seq_bits;
   asc_pkg::asc_ctrl_s word_ctrl;

   assign wr_bit = link_shift[`ASC_POS_WRITE];
   assign seq_bits = {link_shift[`ASC_POS_SEQ], link_shift[`ASC_POS_SHADOW]}; // [RQ23]
   assign word_ctrl = asc_pkg::asc_ctrl_s'(link_shift[10:0]);

   // ---------------- control and channel-select registers
   asc_pkg::asc_ctrl_s ctrl;
   logic shadow_pending;
   logic [15:0] chan_sel;
   logic ctrl_write;

   assign ctrl_write = word_taken & wr_bit & ~shadow_pending;

   // control register, held through every power mode
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         ctrl <= asc_pkg::asc_ctrl_s'(`ASC_CTRL_RESET);
      end else if (ctrl_write) begin
         ctrl <= word_ctrl; // [RQ2] [RQ10] [RQ20]
      end
   end

   // the word after a 0,1 control write goes to channel-select, not control
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         shadow_pending <= 1'b0;
         chan_sel <= 16'h0000;
      end else if (word_taken && shadow_pending) begin
         shadow_pending <= 1'b0;
         chan_sel <= link_shift; // [RQ8] [RQ15]
      end else if (ctrl_write) begin
         shadow_pending <= (seq_bits == 2'b01); // [RQ15]
      end
   end

   // bit 15 of the word, the first one sent, enables channel 0
   logic [15:0] ch_en, word_en;
   genvar gc;
   generate
      for (gc = 0; gc < CHANNELS; gc++) begin : g_chan
         assign ch_en[gc] = chan_sel[15 - gc]; // [RQ16]
         assign word_en[gc] = link_shift[15 - gc];
      end
   endgenerate

   // next enabled channel above cur, or the lowest enabled one on wrap
   function automatic logic [3:0] next_enabled(input logic [15:0] en,
                                               input logic [3:0] cur);
      logic [3:0] lo;
      logic [3:0] up;
      logic found_up;
      lo = 4'h0;
      up = 4'h0;
      found_up = 1'b0;
      for (int k = 15; k >= 0; k--) begin
         if (en[k]) begin
            lo = 4'(k);
         end
         if (en[k] && 4'(k) > cur) begin
            up = 4'(k);
            found_up = 1'b1;
         end
      end
      return found_up ? up : lo; // [RQ26]
   endfunction

   // ---------------- sequencer
   asc_pkg::asc_seq_e seq_mode;
   logic [3:0] next_ch;
   logic [3:0] last_ch;
   logic [3:0] conv_ch;

   // mode follows control writes; a 1,0 write leaves it alone
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         seq_mode <= asc_pkg::SEQ_OFF;
         last_ch <= 4'h0;
      end else if (word_taken && shadow_pending) begin
         seq_mode <= asc_pkg::SEQ_SHADOW; // [RQ9]
      end else if (ctrl_write) begin
         case (seq_bits)
            2'b00: seq_mode <= asc_pkg::SEQ_OFF; // [RQ7] [RQ17]
            2'b01: seq_mode <= asc_pkg::SEQ_OFF; // [RQ17]
            2'b10: seq_mode <= seq_mode; // [RQ10]
            2'b11: begin
               seq_mode <= asc_pkg::SEQ_CONSEC; // [RQ11]
               last_ch <= word_ctrl.channel_address;
            end
            default: seq_mode <= asc_pkg::SEQ_OFF;
         endcase
      end
   end

   // channel for the coming conversion; advanced at each conversion start in a sequence mode, held with the sequencer off
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         next_ch <= 4'h0;
      end else if (word_taken && shadow_pending) begin
         next_ch <= next_enabled(word_en, 4'hF); // [RQ9] new word; past 15 gives lowest
      end else if (ctrl_write && seq_bits == 2'b11) begin
         next_ch <= 4'h0; // [RQ11]
      end else if (ctrl_write && seq_bits != 2'b10) begin
         next_ch <= word_ctrl.channel_address; // [RQ7] [RQ21]
      end else if (conv_start) begin
         case (seq_mode)
            asc_pkg::SEQ_SHADOW: next_ch <= next_enabled(ch_en, next_ch); // [RQ17]
            asc_pkg::SEQ_CONSEC: begin
               next_ch <= (next_ch >= last_ch) ? 4'h0 : next_ch + 4'h1; // [RQ11]
            end
            default: next_ch <= next_ch;
         endcase
      end
   end

   // a control write in flight already names the next channel by the 14th edge
   logic head_write;
   logic [3:0] mux_target;
   assign head_write = link_head[`ASC_POS_WRITE - 2] & ~shadow_pending;
   assign mux_target = (head_write && !link_head[`ASC_POS_SEQ - 2]) ? link_head[7:4] :
      (head_write && link_head[`ASC_POS_SHADOW - 2]) ? 4'h0 : next_ch; // [RQ21] [RQ22]

   // channel under conversion, and the mux switch at the 14th edge
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         conv_ch <= 4'h0;
         o_mux_channel <= 4'h0;
      end else begin
         if (conv_start) begin
            conv_ch <= next_ch; // [RQ9]
         end
         if (mux_event) begin
            o_mux_channel <= mux_target; // [RQ22]
         end else if (conv_start) begin
            o_mux_channel <= next_ch;
         end
      end
   end

   // ---------------- power management
   asc_pkg::asc_pwr_e pwr;
   logic [7:0] wake_count;
   logic wake_timed;

   // auto modes drop power after a conversion that carried a control write
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         pwr <= asc_pkg::PWR_ACTIVE;
         wake_count <= 8'h00;
         wake_timed <= 1'b0;
      end else if (ctrl_write) begin
         case ({word_ctrl.power_mode_hi, word_ctrl.power_mode_lo})
            2'b11: pwr <= asc_pkg::PWR_ACTIVE; // [RQ1]
            2'b10: pwr <= asc_pkg::PWR_SHUTDOWN; // [RQ2] [RQ3]
            2'b01: pwr <= asc_pkg::PWR_SHUTDOWN; // [RQ4]
            2'b00: pwr <= asc_pkg::PWR_STANDBY; // [RQ6]
            default: pwr <= asc_pkg::PWR_ACTIVE;
         endcase
      end else begin
         case (pwr)
            asc_pkg::PWR_SHUTDOWN: begin
               // full shutdown ignores chip select; only auto shutdown wakes
               if (conv_start && !ctrl.power_mode_hi) begin
                  pwr <= asc_pkg::PWR_WAKING; // [RQ5]
                  wake_count <= WAKE_CYC;
                  wake_timed <= 1'b1;
               end
            end
            asc_pkg::PWR_STANDBY: begin
               if (conv_start) begin
                  pwr <= asc_pkg::PWR_WAKING;
                  wake_timed <= 1'b0;
               end
            end
            asc_pkg::PWR_WAKING: begin
               if (wake_timed) begin
                  wake_count <= wake_count - 8'h01;
                  if (wake_count == 8'h01) begin
                     pwr <= asc_pkg::PWR_ACTIVE;
                     wake_timed <= 1'b0; // so the next timed wake shows a fresh rise
                  end
               end else if (word_taken) begin
                  pwr <= asc_pkg::PWR_ACTIVE; // [RQ6]
               end
            end
            default: pwr <= asc_pkg::PWR_ACTIVE;
         endcase
      end
   end

   assign o_ctrl = ctrl;
   assign o_power_state = pwr;
   assign o_seq_mode = seq_mode;
   assign o_channel_select = chan_sel;
   assign o_conv_channel = conv_ch;
   assign o_range_double = ~ctrl.range_single; // [RQ20]
   assign o_ready = (pwr == asc_pkg::PWR_ACTIVE);

   // ---------------- checks
   a_full_on: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [RQ1]
      ctrl_write && word_ctrl.power_mode_hi && word_ctrl.power_mode_lo
      |=> (pwr == asc_pkg::PWR_ACTIVE) [*3])
      else $error("normal mode did not stay powered");

   a_shutdown_hold: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [RQ2]
      ctrl.power_mode_hi && !ctrl.power_mode_lo && pwr == asc_pkg::PWR_SHUTDOWN
      && !ctrl_write |=> pwr == asc_pkg::PWR_SHUTDOWN && ctrl == $past(ctrl))
      else $error("full shutdown left or control lost");

   a_auto_down: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [RQ4]
      ctrl_write && !word_ctrl.power_mode_hi && word_ctrl.power_mode_lo
      |=> pwr == asc_pkg::PWR_SHUTDOWN)
      else $error("auto shutdown not entered");

   a_wake_time: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [RQ5]
      $rose(wake_timed) |-> !o_ready [*8] ##[17:19] o_ready)
      else $error("wake-up time wrong");

   a_standby_entry: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [RQ6]
      ctrl_write && !word_ctrl.power_mode_hi && !word_ctrl.power_mode_lo
      |=> pwr == asc_pkg::PWR_STANDBY)
      else $error("standby not entered");

   a_addr_select: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [RQ7]
      ctrl_write && seq_bits == 2'b00
      |=> next_ch == $past(word_ctrl.channel_address) && seq_mode == asc_pkg::SEQ_OFF)
      else $error("address not taken for next conversion");

   a_shadow_load: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [RQ8]
      word_taken && shadow_pending
      |=> chan_sel == $past(link_shift) && !shadow_pending
      && seq_mode == asc_pkg::SEQ_SHADOW)
      else $error("channel-select load failed");

   a_seq_keep: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [RQ10]
      ctrl_write && seq_bits == 2'b10
      |=> seq_mode == $past(seq_mode) && next_ch == $past(next_ch))
      else $error("sequence disturbed by 1,0 write");

   a_consec_wrap: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [RQ11]
      conv_start && !word_taken && seq_mode == asc_pkg::SEQ_CONSEC
      && next_ch == last_ch |=> next_ch == 4'h0)
      else $error("consecutive sequence did not wrap to 0");

   a_mux_switch: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [RQ22]
      mux_event |=> o_mux_channel == $past(mux_target))
      else $error("mux not switched at edge 14");

endmodule

// ### test/asc_host.sv
`timescale 1ns/1ps
// host serial master; the link clock only runs inside a frame and idles high
module asc_host (
   output logic o_sclk,
   output logic o_cs_n,
   output logic o_din
);
   // idle link before the first frame
   initial begin
      o_sclk = 1'b1;
      o_cs_n = 1'b1;
      o_din = 1'b0;
   end

   // one frame, msb first; fewer than 16 edges gives a frame the device must drop
   task automatic send(input logic [15:0] word, input int n_edges);
      #7 o_cs_n = 1'b0;
      #400;
      for (int i = 15; i > 15 - n_edges; i--) begin
         o_din = word[i];
         #24 o_sclk = 1'b0;
         #24 o_sclk = 1'b1;
      end
      #200 o_cs_n = 1'b1;
      o_din = ~o_din; // a released line must not keep showing the last bit
      #200;
   endtask
endmodule

// ### test/tb_asc_sequencer.sv
`timescale 1ns/1ps
module tb_asc_sequencer;
   logic i_clock = 1'b0;
   logic i_reset_n = 1'b0;
   logic sclk, cs_n, din, r, range_double, ready;
   asc_pkg::asc_ctrl_s ctrl;
   asc_pkg::asc_pwr_e pwr;
   asc_pkg::asc_seq_e mode;
   logic [3:0] mux, conv, a, exp_ch;
   logic [15:0] w, lw, mask, sel;
   int num_errors = 0;
   int n_tests = 0;

   // 25 MHz core clock
   always #20 i_clock = ~i_clock;

   asc_host host (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din));
   asc_sequencer dut (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_sclk(sclk),
      .i_cs_n(cs_n), .i_din(din), .o_ctrl(ctrl), .o_power_state(pwr),
      .o_seq_mode(mode), .o_channel_select(sel), .o_mux_channel(mux),
      .o_conv_channel(conv), .o_range_double(range_double), .o_ready(ready));

   task automatic check(input string what, input logic [15:0] seen,
         input logic [15:0] want);
      n_tests++;
      if (seen !== want) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, want, seen);
      end
   endtask

   task automatic close_out();
      if (num_errors == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // write flag goes at bit 15 and bit 11 so either framing reads it
   function automatic logic [15:0] mk(input logic wr, input logic sq,
         input logic [3:0] ad, input logic [1:0] pm, input logic sh, input logic rg);
      return {wr, 3'h0, wr, sq, ad, pm, sh, 1'b0, rg, 1'b0};
   endfunction

   // channel mask to wire order: channel 0 travels first
   function automatic logic [15:0] rev(input logic [15:0] m);
      for (int c = 0; c < 16; c++) begin
         rev[15 - c] = m[c];
      end
   endfunction

   // next enabled channel above cur, wrapping to the lowest
   function automatic logic [3:0] nxt(input logic [15:0] m, input logic [3:0] cur);
      for (int i = 1; i <= 16; i++) begin
         if (m[(cur + i) % 16]) begin
            return 4'((cur + i) % 16);
         end
      end
      return cur;
   endfunction

   // frame plus settle time for the core to act on the word
   task automatic frame(input logic [15:0] fw, input int n = 16);
      host.send(fw, n);
      repeat (6) @(posedge i_clock);
      @(negedge i_clock); // look at registered outputs away from their launch edge
   endtask

   // hang guard
   initial begin
      repeat (60000) @(posedge i_clock);
      num_errors++;
      close_out();
   end

   // main sequence
   initial begin
      void'($urandom(68386));
      repeat (5) @(posedge i_clock);
      i_reset_n <= 1'b1;
      repeat (2) @(posedge i_clock);
      @(negedge i_clock);
      check("ctrl", 16'(ctrl), 16'h0032);
      check("power", 16'(pwr), 16'(asc_pkg::PWR_ACTIVE));
      check("ready", 16'(ready), 16'h0001);
      for (int k = 0; k < 4; k++) begin
         a = (k == 0) ? 4'hF : 4'($urandom_range(0, 15));
         r = 1'($urandom);
         lw = mk(1'b1, 1'b0, a, 2'h3, 1'b0, r);
         frame(lw);
         check("ctrl", 16'(ctrl), {5'h00, lw[10:0]});
         check("range", 16'(range_double), 16'(!r));
         check("mux", 16'(mux), 16'(a));
         frame(16'h0000);
         check("conv", 16'(conv), 16'(a));
      end
      // write bit low and a short frame both leave control alone
      frame(mk(1'b0, 1'b1, 4'h5, 2'h2, 1'b1, 1'b0));
      frame(mk(1'b1, 1'b0, 4'h3, 2'h2, 1'b0, 1'b0), 15);
      check("ctrl", 16'(ctrl), {5'h00, lw[10:0]});
      check("select", sel, 16'h0000);
      // full shutdown holds until the power bits change
      w = mk(1'b1, 1'b0, 4'h2, 2'h2, 1'b0, 1'b1);
      frame(w);
      check("power", 16'(pwr), 16'(asc_pkg::PWR_SHUTDOWN));
      frame(16'h0000);
      check("power", 16'(pwr), 16'(asc_pkg::PWR_SHUTDOWN));
      check("ctrl", 16'(ctrl), {5'h00, w[10:0]});
      // auto shutdown then auto standby: drop after a write, wake on next frame
      for (int j = 0; j < 2; j++) begin
         frame(mk(1'b1, 1'b0, 4'h2, (j == 0) ? 2'h1 : 2'h0, 1'b0, 1'b1));
         check("power", 16'(pwr), (j == 0) ? 16'h0002 : 16'h0001);
         fork
            frame(16'h0000);
            begin
               repeat (12) @(negedge i_clock);
               check("power", 16'(pwr), 16'(asc_pkg::PWR_WAKING));
            end
         join
         check("ready", 16'(ready), 16'h0001);
      end
      frame(mk(1'b1, 1'b0, 4'h0, 2'h3, 1'b0, 1'b1));
      // channel-select sequences: sparse corner mask, then a random one
      for (int k = 0; k < 2; k++) begin
         mask = (k == 0) ? 16'h8005 : 16'($urandom) | 16'h0100;
         frame(mk(1'b1, 1'b0, 4'h0, 2'h3, 1'b1, 1'b1));
         frame(rev(mask));
         check("mode", 16'(mode), 16'(asc_pkg::SEQ_SHADOW));
         check("select", sel, rev(mask));
         exp_ch = nxt(mask, 4'hF);
         for (int f = 0; f < 8; f++) begin
            if (f == 3) begin
               frame(mk(1'b1, 1'b1, 4'h0, 2'h3, 1'b0, 1'b0));
               check("range", 16'(range_double), 16'h0001);
            end else begin
               frame(16'h0000);
            end
            check("conv", 16'(conv), 16'(exp_ch));
            exp_ch = nxt(mask, exp_ch);
            check("mux", 16'(mux), 16'(exp_ch));
         end
         frame(mk(1'b1, 1'b0, 4'h4, 2'h3, 1'b0, 1'b1));
         check("mode", 16'(mode), 16'(asc_pkg::SEQ_OFF));
         check("select", sel, rev(mask));
      end
      // consecutive channels 0 up to a random final channel
      a = 4'($urandom_range(1, 4));
      frame(mk(1'b1, 1'b1, a, 2'h3, 1'b1, 1'b1));
      check("mode", 16'(mode), 16'(asc_pkg::SEQ_CONSEC));
      for (int f = 0; f < 2 * a + 3; f++) begin
         frame(16'h0000);
         check("conv", 16'(conv), 16'(f % (a + 1)));
      end
      close_out();
   end
endmodule
